//--- core/dbus_cfg.svh
`ifndef DBUS_CFG_SVH
`define DBUS_CFG_SVH

// Discrete register addresses
`define ADDR_OPERAND      8'h7C
`define ADDR_HALF_STAT    8'h7D
`define ADDR_STAT         8'h7E
`define ADDR_PSW_CC       8'h7F
`define ADDR_CONSOLE      8'hFC
`define ADDR_ALU_CC_WR    8'hFD
`define ADDR_ALU_CC       8'hFE
`define ADDR_PSW_CC_HI    8'hFF
`define DISCRETE_TAG      5'h1F
// Two-operand fields from here up write back
`define TWO_OP_WR_MIN     6'h20
// Transfer field codes
`define XFER_MEM_A        3'h0
`define XFER_RD_A         3'h1
`define XFER_OPND_A       3'h2
`define XFER_RD_B         3'h3
`define XFER_MEM_B        3'h4
`define XFER_OPND_B       3'h6
// Local store mirror of the status word
`define LS_PSW_ADDR       8'h1D
`define PSW_MIRROR_MASK   32'h83FF0000
// Widths and reset values
`define STAT_WIDTH        8
`define OPERAND_RST       8'h00
`define PSW_RST           32'h00000000
`define CC_RST            4'h0

`endif

//--- core/dbus_ctl.sv
`include "dbus_cfg.svh"
`default_nettype none
module dbus_ctl #(
	parameter int STAT_W = `STAT_WIDTH
) (
	// Clock, reset, enable
	input  wire logic                CLK_IN,
	input  wire logic                SRST_IN,
	input  wire logic                CE_IN,
	// Microinstruction and data sources
	input  wire dbus_pkg::micro_type MICRO_IN,
	input  wire logic                DATA_REQ_IN,
	input  wire logic                SIZE_BIT0_IN,
	input  wire logic [15:0]         MCB_DATA_IN,
	input  wire logic [31:0]         Y_BUS_IN,
	// Hardware updates
	input  wire logic [3:0]          ALU_FLAGS_IN,
	input  wire logic                ALU_FLAGS_LOAD_IN,
	input  wire logic                HALF_CARRY_IN,
	input  wire logic                CONSOLE_LOAD_IN,
	input  wire logic [31:0]         CONSOLE_DATA_IN,
	// Decode
	output logic                     REG_SELECT_OUT,
	output dbus_pkg::access_type     ACCESS_OUT,
	// Register read drivers
	output logic      [31:0]         DBUS_REG_OUT,
	output logic                     DBUS_LO_OE_N_OUT,
	output logic                     DBUS_HI_OE_N_OUT,
	// Sign drivers and transceiver control
	output logic      [15:0]         SIGN_UPPER_OUT,
	output logic                     SIGN_UPPER_OE_N_OUT,
	output logic      [7:0]          SIGN_B1_OUT,
	output logic                     SIGN_B1_OE_N_OUT,
	output logic                     XCVR_UPPER_OFF_OUT,
	output logic                     XCVR_B1_OFF_OUT,
	// Register contents
	output logic      [31:0]         PSW_OUT,
	output logic      [3:0]          STATUS_CC_OUT,
	output logic      [3:0]          ARITH_CC_OUT,
	output logic      [7:0]          OPERAND_OUT,
	output logic      [STAT_W-1:0]   STAT_OUT,
	// Local store mirror write
	output logic                     LS_MIRROR_WE_OUT,
	output logic      [7:0]          LS_MIRROR_ADDR_OUT,
	output logic      [31:0]         LS_MIRROR_DATA_OUT
);

	if (STAT_W < 1 || STAT_W > 32) begin : g_bad_width
		$error("STAT_W must lie between 1 and 32");
	end

	dbus_pkg::access_type   acc;
	dbus_pkg::sign_src_type src;
	logic                   sign_bit;
	logic [31:0]            rd_val;
	logic                   any_rd;

	logic [7:0]        operand_q;
	logic [STAT_W-1:0] stat_q;
	logic [31:0]       psw_q;
	logic [3:0]        pscc_q;
	logic [3:0]        alucc_q;
	logic              half_q;
	logic [31:0]       console_q;
	logic [31:0]       rd_q;
	logic              lo_oe_n_q;
	logic              hi_oe_n_q;
	logic              xu_q;
	logic              xb_q;
	logic              mirror_we_q;
	logic [31:0]       mirror_q;

	// Two-operand addresses carry only seven bits
	function automatic logic [7:0] eff_addr(input dbus_pkg::micro_type m);
		eff_addr = m.two_op ? {1'b0, m.addr[6:0]} : m.addr;
	endfunction

	function automatic logic is_discrete(input dbus_pkg::micro_type m);
		logic [7:0] a;
		a = eff_addr(m);
		is_discrete = (m.two_op | m.transfer) && (a[6:2] == `DISCRETE_TAG);
	endfunction

	function automatic dbus_pkg::access_type decode(input dbus_pkg::micro_type m);
		dbus_pkg::access_type a;
		logic [2:0] xf;
		logic       rd_ok;
		logic       wr_ok;
		a  = '0;
		xf = m.field[2:0];
		if (m.two_op) begin
			rd_ok = 1'b1;
			wr_ok = (m.field >= `TWO_OP_WR_MIN);
		end else begin
			rd_ok = !(xf == `XFER_MEM_A || xf == `XFER_MEM_B);
			wr_ok = !(xf == `XFER_RD_A || xf == `XFER_OPND_A || xf == `XFER_RD_B);
		end
		if (m.transfer && (xf == `XFER_OPND_A || xf == `XFER_OPND_B)) begin
			a.rd_operand = 1'b1;
		end else if (is_discrete(m)) begin
			case (eff_addr(m))
				`ADDR_OPERAND: begin
					a.rd_operand = rd_ok;
					a.wr_operand = wr_ok;
				end
				`ADDR_HALF_STAT: begin
					a.rd_half = rd_ok;
					a.wr_stat = wr_ok;
				end
				`ADDR_STAT: begin
					a.rd_stat = rd_ok;
					a.wr_stat = wr_ok;
				end
				`ADDR_PSW_CC, `ADDR_PSW_CC_HI: begin
					a.rd_pscc = rd_ok;
					a.wr_pscc = wr_ok;
					a.wr_status_word = wr_ok & m.transfer;
				end
				`ADDR_CONSOLE: begin
					a.rd_console     = rd_ok;
					a.wr_pscc        = wr_ok;
					a.wr_status_word = wr_ok;
				end
				`ADDR_ALU_CC_WR: begin
					a.wr_alucc = wr_ok;
				end
				`ADDR_ALU_CC: begin
					a.rd_alucc = rd_ok;
					a.wr_alucc = wr_ok;
				end
				default: begin
					a = '0;
				end
			endcase
		end
		decode = a;
	endfunction

	assign acc            = decode(MICRO_IN);
	assign ACCESS_OUT     = acc;
	assign REG_SELECT_OUT = is_discrete(MICRO_IN);

	// Memory data owns the bus over any operand read in the same cycle
	always_comb begin
		src = dbus_pkg::SRC_NONE;
		if (MICRO_IN.transfer && DATA_REQ_IN) begin
			src = SIZE_BIT0_IN ? dbus_pkg::SRC_MEM_WORD : dbus_pkg::SRC_MEM_BYTE;
		end else if (acc.rd_operand) begin
			src = dbus_pkg::SRC_OPERAND;
		end
	end

	always_comb begin
		case (src)
			dbus_pkg::SRC_MEM_WORD: sign_bit = MCB_DATA_IN[15];
			dbus_pkg::SRC_MEM_BYTE: sign_bit = MCB_DATA_IN[7];
			default:                sign_bit = operand_q[7];
		endcase
	end

	sign_fill i_sign_fill (
		.clk_in         (CLK_IN),
		.srst_in        (SRST_IN),
		.ce_in          (CE_IN),
		.sign_in        (sign_bit),
		.en_upper_in    (src != dbus_pkg::SRC_NONE),
		.en_b1_in       (src == dbus_pkg::SRC_OPERAND || src == dbus_pkg::SRC_MEM_BYTE),
		.upper_out      (SIGN_UPPER_OUT),
		.upper_oe_n_out (SIGN_UPPER_OE_N_OUT),
		.b1_out         (SIGN_B1_OUT),
		.b1_oe_n_out    (SIGN_B1_OE_N_OUT)
	);

	// Transceivers released only while sign drivers own the high lines
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			xu_q <= 1'b0;
			xb_q <= 1'b0;
		end else if (CE_IN) begin
			xu_q <= (src == dbus_pkg::SRC_MEM_BYTE || src == dbus_pkg::SRC_MEM_WORD);
			xb_q <= (src == dbus_pkg::SRC_MEM_BYTE);
		end
	end

	always_comb begin
		rd_val = 32'h00000000;
		case (1'b1)
			acc.rd_operand: rd_val = {24'h000000, operand_q};
			acc.rd_half:  rd_val = {31'h00000000, half_q};
			acc.rd_stat:  rd_val = 32'(stat_q);
			acc.rd_pscc:  rd_val = {28'h0000000, pscc_q};
			acc.rd_console: rd_val = console_q;
			acc.rd_alucc: rd_val = {28'h0000000, alucc_q};
			default:      rd_val = 32'h00000000;
		endcase
	end

	assign any_rd = acc.rd_operand | acc.rd_half | acc.rd_stat | acc.rd_pscc
		| acc.rd_console | acc.rd_alucc;

	// Read data held for the microcycle after the decode; operand high lines left to sign fill
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			rd_q      <= 32'h00000000;
			lo_oe_n_q <= 1'b1;
			hi_oe_n_q <= 1'b1;
		end else if (CE_IN) begin
			rd_q      <= rd_val;
			lo_oe_n_q <= ~any_rd;
			hi_oe_n_q <= ~(any_rd & ~acc.rd_operand);
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			operand_q <= `OPERAND_RST;
		end else if (CE_IN && acc.wr_operand) begin
			operand_q <= Y_BUS_IN[7:0];
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			stat_q <= '0;
		end else if (CE_IN && acc.wr_stat) begin
			stat_q <= Y_BUS_IN[STAT_W-1:0];
		end
	end

	// Discrete status word; mode and level bits mirrored to local store
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			psw_q       <= `PSW_RST;
			mirror_we_q <= 1'b0;
			mirror_q    <= 32'h00000000;
		end else if (CE_IN) begin
			mirror_we_q <= acc.wr_status_word;
			if (acc.wr_status_word) begin
				psw_q    <= Y_BUS_IN;
				mirror_q <= Y_BUS_IN & `PSW_MIRROR_MASK;
			end
		end
	end

	// Condition codes never reach the mirror, so a save must read them first
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			pscc_q <= `CC_RST;
		end else if (CE_IN && acc.wr_pscc) begin
			pscc_q <= Y_BUS_IN[3:0];
		end
	end

	// A microcode write overrides a same-cycle hardware flag load
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			alucc_q <= `CC_RST;
		end else if (CE_IN && acc.wr_alucc) begin
			alucc_q <= Y_BUS_IN[3:0];
		end else if (CE_IN && ALU_FLAGS_LOAD_IN) begin
			alucc_q <= ALU_FLAGS_IN;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			half_q <= 1'b0;
			console_q <= 32'h00000000;
		end else if (CE_IN) begin
			half_q <= HALF_CARRY_IN;
			if (CONSOLE_LOAD_IN) begin
				console_q <= CONSOLE_DATA_IN;
			end
		end
	end

	assign DBUS_REG_OUT       = rd_q;
	assign DBUS_LO_OE_N_OUT   = lo_oe_n_q;
	assign DBUS_HI_OE_N_OUT   = hi_oe_n_q;
	assign XCVR_UPPER_OFF_OUT = xu_q;
	assign XCVR_B1_OFF_OUT    = xb_q;
	assign PSW_OUT            = {psw_q[31:4], pscc_q};
	assign STATUS_CC_OUT      = pscc_q;
	assign ARITH_CC_OUT       = alucc_q;
	assign OPERAND_OUT        = operand_q;
	assign STAT_OUT           = stat_q;
	assign LS_MIRROR_WE_OUT   = mirror_we_q;
	assign LS_MIRROR_ADDR_OUT = `LS_PSW_ADDR;
	assign LS_MIRROR_DATA_OUT = mirror_q;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SRST_IN);

	logic [2:0] xf_w;
	assign xf_w = MICRO_IN.field[2:0];

	select_range_a: assert property (REG_SELECT_OUT |->
		(MICRO_IN.two_op || MICRO_IN.transfer) && MICRO_IN.addr[6:2] == 5'h1F)
		else $error("register select outside discrete range");

	two_op_nowr_a: assert property (CE_IN && MICRO_IN.two_op && MICRO_IN.field < 6'h20
		|=> $stable(OPERAND_OUT) && $stable(STATUS_CC_OUT) && $stable(STAT_OUT))
		else $error("two-operand low field wrote a register");

	operand_rmw_a: assert property (CE_IN && MICRO_IN.two_op && MICRO_IN.addr[6:0] == 7'h7C
		&& MICRO_IN.field >= 6'h20 |=> OPERAND_OUT == $past(Y_BUS_IN[7:0])
		&& !DBUS_LO_OE_N_OUT && DBUS_HI_OE_N_OUT)
		else $error("operand read-modify-write failed");

	mem_noread_a: assert property (CE_IN && MICRO_IN.transfer
		&& (xf_w == 3'h0 || xf_w == 3'h4) |=> DBUS_LO_OE_N_OUT && DBUS_HI_OE_N_OUT)
		else $error("register read during memory field");

	byte_fill_a: assert property (CE_IN && MICRO_IN.transfer && DATA_REQ_IN && !SIZE_BIT0_IN
		|=> !SIGN_UPPER_OE_N_OUT && !SIGN_B1_OE_N_OUT && XCVR_B1_OFF_OUT
		&& SIGN_UPPER_OUT == {16{$past(MCB_DATA_IN[7])}} && SIGN_B1_OUT == {8{$past(MCB_DATA_IN[7])}})
		else $error("memory byte sign fill wrong");

	word_fill_a: assert property (CE_IN && MICRO_IN.transfer && DATA_REQ_IN && SIZE_BIT0_IN
		|=> !SIGN_UPPER_OE_N_OUT && SIGN_B1_OE_N_OUT && XCVR_UPPER_OFF_OUT && !XCVR_B1_OFF_OUT
		&& SIGN_UPPER_OUT == {16{$past(MCB_DATA_IN[15])}})
		else $error("memory word sign fill wrong");

	operand_fill_a: assert property (CE_IN && MICRO_IN.two_op && MICRO_IN.addr[6:0] == 7'h7C
		|=> !SIGN_B1_OE_N_OUT && SIGN_B1_OUT == {8{$past(OPERAND_OUT[7])}} && !XCVR_UPPER_OFF_OUT)
		else $error("operand sign fill wrong");

	idle_hiz_a: assert property (CE_IN && !MICRO_IN.two_op && !MICRO_IN.transfer
		|=> SIGN_UPPER_OE_N_OUT && SIGN_B1_OE_N_OUT)
		else $error("sign drivers active when idle");

	psw_mirror_a: assert property (CE_IN && MICRO_IN.transfer && MICRO_IN.addr == 8'hFF
		&& (xf_w == 3'h0 || xf_w == 3'h5) |=> LS_MIRROR_WE_OUT
		&& LS_MIRROR_ADDR_OUT == 8'h1D && PSW_OUT[31:4] == $past(Y_BUS_IN[31:4])
		&& LS_MIRROR_DATA_OUT == ($past(Y_BUS_IN) & 32'h83FF0000))
		else $error("status word write or mirror wrong");

	flag_wronly_a: assert property (CE_IN && MICRO_IN.transfer && MICRO_IN.addr == 8'hFD
		&& xf_w == 3'h5 ##0 !ALU_FLAGS_LOAD_IN
		|=> DBUS_LO_OE_N_OUT && ARITH_CC_OUT == $past(Y_BUS_IN[3:0]))
		else $error("arith flag write-only access wrong");

	frozen_a: assert property (!CE_IN |=> $stable(OPERAND_OUT) && $stable(PSW_OUT)
		&& $stable(SIGN_UPPER_OE_N_OUT) && $stable(DBUS_REG_OUT))
		else $error("state moved with clock enable low");

	byte_fill_c: cover property (CE_IN && MICRO_IN.transfer && DATA_REQ_IN && !SIZE_BIT0_IN);
	word_fill_c: cover property (CE_IN && MICRO_IN.transfer && DATA_REQ_IN && SIZE_BIT0_IN);
	operand_rmw_c: cover property (CE_IN && acc.rd_operand && acc.wr_operand);
	psw_write_c: cover property (CE_IN && acc.wr_status_word ##1 LS_MIRROR_WE_OUT);

endmodule // dbus_ctl
`default_nettype wire

//--- core/dbus_pkg.sv
`default_nettype none
package dbus_pkg;

	typedef struct packed {
		logic       two_op;
		logic       transfer;
		logic [7:0] addr;
		logic [5:0] field;
	} micro_type;

	typedef struct packed {
		logic rd_operand;
		logic rd_half;
		logic rd_stat;
		logic rd_pscc;
		logic rd_console;
		logic rd_alucc;
		logic wr_operand;
		logic wr_stat;
		logic wr_pscc;
		logic wr_status_word;
		logic wr_alucc;
	} access_type;

	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_OPERAND,
		SRC_MEM_BYTE,
		SRC_MEM_WORD
	} sign_src_type;

endpackage
`default_nettype wire

//--- core/sign_fill.sv
`default_nettype none
module sign_fill (
	// Clock, reset, enable
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic        ce_in,
	// Selected sign and enables
	input  wire logic        sign_in,
	input  wire logic        en_upper_in,
	input  wire logic        en_b1_in,
	// Driver groups
	output logic      [15:0] upper_out,
	output logic             upper_oe_n_out,
	output logic      [7:0]  b1_out,
	output logic             b1_oe_n_out
);

	// Two latch groups, each with its own enable
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			upper_out      <= 16'h0000;
			upper_oe_n_out <= 1'b1;
		end else if (ce_in) begin
			upper_out      <= {16{sign_in}};
			upper_oe_n_out <= ~en_upper_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			b1_out      <= 8'h00;
			b1_oe_n_out <= 1'b1;
		end else if (ce_in) begin
			b1_out      <= {8{sign_in}};
			b1_oe_n_out <= ~en_b1_in;
		end
	end

endmodule // sign_fill
`default_nettype wire

//--- tb/dbus_register_access_sign_extend_tb.sv
`default_nettype none
module dbus_register_access_sign_extend_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 clk = 1'b0;
	logic                 srst = 1'b1;
	logic                 req = 1'b0;
	logic                 size = 1'b0;
	logic                 flags_ld = 1'b0;
	logic [3:0]           flags = 4'h0;
	logic                 ce = 1'b1;
	logic                 cload = 1'b0;
	logic [31:0]          cdata = 32'h00000000;
	logic [15:0]          word = 16'h0000;
	logic [31:0]          y = 32'h00000000;
	dbus_pkg::micro_type  micro = '0;
	wire logic [15:0]     mcb;
	dbus_pkg::access_type acc;
	logic                 reg_sel, lo_oe_n, hi_oe_n, sup_oe_n, sb1_oe_n, x_up, x_b1, ls_we;
	logic [31:0]          dreg, psw, ls_data;
	logic [15:0]          sup;
	logic [7:0]           sb1, opnd, stat, ls_addr;
	logic [3:0]           scc, acc_cc;
	int                   fails = 0;
	int                   total_checks = 0;
	// {kind 1=two-operand 2=transfer, address, field, expected access bits}
	logic [31:0]          tbl [23] = '{32'h17C1F400, 32'h17C20410, 32'h17F20084, 32'h17D00200,
		32'h17E20108, 32'h17B20000, 32'h27C00010, 32'h27C03400, 32'h27C04010, 32'h27C06400,
		32'h27C07410, 32'h27D01200, 32'h27D05208, 32'h27E03100, 32'h27E05108, 32'h27F00006,
		32'h2FC01040, 32'h2FC05046, 32'h2FD05001, 32'h2FE01020, 32'h2FE00001, 32'h2FF05086,
		32'h28005000};

	always #5 clk = ~clk;

	mcb_model i_mcb_model (.clk_in(clk), .req_in(req), .word_in(word), .mcb_out(mcb));

	dbus_ctl i_dbus_ctl (
		.CLK_IN(clk), .SRST_IN(srst), .CE_IN(ce), .MICRO_IN(micro), .DATA_REQ_IN(req),
		.SIZE_BIT0_IN(size), .MCB_DATA_IN(mcb), .Y_BUS_IN(y), .ALU_FLAGS_IN(flags),
		.ALU_FLAGS_LOAD_IN(flags_ld), .HALF_CARRY_IN(1'b1), .CONSOLE_LOAD_IN(cload),
		.CONSOLE_DATA_IN(cdata), .REG_SELECT_OUT(reg_sel), .ACCESS_OUT(acc),
		.DBUS_REG_OUT(dreg), .DBUS_LO_OE_N_OUT(lo_oe_n), .DBUS_HI_OE_N_OUT(hi_oe_n),
		.SIGN_UPPER_OUT(sup), .SIGN_UPPER_OE_N_OUT(sup_oe_n), .SIGN_B1_OUT(sb1),
		.SIGN_B1_OE_N_OUT(sb1_oe_n), .XCVR_UPPER_OFF_OUT(x_up), .XCVR_B1_OFF_OUT(x_b1),
		.PSW_OUT(psw), .STATUS_CC_OUT(scc), .ARITH_CC_OUT(acc_cc), .OPERAND_OUT(opnd),
		.STAT_OUT(stat), .LS_MIRROR_WE_OUT(ls_we), .LS_MIRROR_ADDR_OUT(ls_addr),
		.LS_MIRROR_DATA_OUT(ls_data)
	);

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic put(input logic two, input logic tr, input logic [7:0] a,
		input logic [5:0] f, input logic [31:0] v);
		@(posedge clk);
		#1;
		micro = '{two, tr, a, f};
		y = v;
	endtask

	// Idle after the taking edge; registered answers are then settled
	task automatic go;
		@(posedge clk);
		#1;
		micro.two_op = 1'b0;
		micro.transfer = 1'b0;
		req = 1'b0;
	endtask

	task automatic op(input logic two, input logic tr, input logic [7:0] a,
		input logic [5:0] f, input logic [31:0] v);
		put(two, tr, a, f, v);
		go();
	endtask

	task automatic memop(input logic sz, input logic [15:0] w, input logic [7:0] a,
		input logic [5:0] f);
		put(1'b0, 1'b1, a, f, 32'h00000000);
		req = 1'b1;
		size = sz;
		word = w;
		go();
	endtask

	task automatic t_reset;
		chk("psw", 32'h00000000, psw);
		chk("sign oe", 32'h3, {30'h0, sup_oe_n, sb1_oe_n});
		chk("reg oe", 32'h3, {30'h0, lo_oe_n, hi_oe_n});
		chk("operand", 32'h0, {24'h0, opnd});
		chk("xcvr mirror", 32'h0, {29'h0, x_up, x_b1, ls_we});
		$display("test reset done");
	endtask

	task automatic t_map;
		for (int i = 0; i < 23; i++) begin
			put(tbl[i][28], tbl[i][29], tbl[i][27:20], tbl[i][17:12], 32'h00000000);
			#1;
			chk("access", {21'h0, tbl[i][10:0]}, {21'h0, acc});
			chk("select", {31'h0, tbl[i][26:22] == 5'h1F}, {31'h0, reg_sel});
		end
		go();
		$display("test access map done");
	endtask

	task automatic t_status;
		op(1'b0, 1'b1, 8'hFF, 6'h05, 32'h876543A9);
		chk("psw", 32'h876543A9, psw);
		chk("status cc", 32'h9, {28'h0, scc});
		chk("mirror we", 32'h1, {31'h0, ls_we});
		chk("mirror addr", 32'h1D, {24'h0, ls_addr});
		chk("mirror data", 32'h83650000, ls_data);
		op(1'b0, 1'b1, 8'hFF, 6'h01, 32'h00000000);
		chk("cc merge", 32'h83650009, {ls_data[31:4], dreg[3:0]});
		$display("test status word done");
	endtask

	task automatic t_writes;
		op(1'b1, 1'b0, 8'h7C, 6'h1F, 32'h00000055);
		chk("operand", 32'h00, {24'h0, opnd});
		op(1'b1, 1'b0, 8'h7C, 6'h20, 32'h000000A5);
		chk("operand", 32'hA5, {24'h0, opnd});
		for (int f = 1; f < 4; f++) begin
			op(1'b0, 1'b1, 8'h7C, 6'(f), 32'h0000003C);
			chk("operand", 32'hA5, {24'h0, opnd});
		end
		op(1'b0, 1'b1, 8'h7C, 6'h04, 32'h00000081);
		chk("operand", 32'h81, {24'h0, opnd});
		op(1'b0, 1'b1, 8'hFD, 6'h05, 32'h00000009);
		chk("arith cc", 32'h9, {28'h0, acc_cc});
		op(1'b1, 1'b0, 8'h7D, 6'h20, 32'h0000005A);
		chk("stat", 32'h5A, {24'h0, stat});
		chk("half carry", 32'h1, dreg);
		// Microcode write and hardware load meet in one cycle: microcode wins
		flags = 4'h3;
		flags_ld = 1'b1;
		op(1'b0, 1'b1, 8'hFD, 6'h05, 32'h00000006);
		chk("arith cc", 32'h6, {28'h0, acc_cc});
		@(posedge clk);
		#1;
		flags_ld = 1'b0;
		chk("arith cc", 32'h3, {28'h0, acc_cc});
		cdata = 32'hC3A5965A;
		cload = 1'b1;
		@(posedge clk);
		#1;
		cload = 1'b0;
		op(1'b0, 1'b1, 8'hFC, 6'h01, 32'h00000000);
		chk("console", 32'hC3A5965A, dreg);
		$display("test writes done");
	endtask

	task automatic t_mem;
		memop(1'b0, 16'h0080, 8'h00, 6'h00);
		chk("byte sign", 32'hFFFFFF, {8'h0, sup, sb1});
		chk("byte oe", 32'h0, {30'h0, sup_oe_n, sb1_oe_n});
		chk("byte xcvr", 32'h3, {30'h0, x_up, x_b1});
		memop(1'b0, 16'hFF7F, 8'h00, 6'h04);
		chk("byte sign", 32'h000000, {8'h0, sup, sb1});
		memop(1'b1, 16'h8000, 8'h00, 6'h00);
		chk("word sign", 32'hFFFF, {16'h0, sup});
		chk("word oe", 32'h1, {30'h0, sup_oe_n, sb1_oe_n});
		chk("word xcvr", 32'h2, {30'h0, x_up, x_b1});
		memop(1'b1, 16'h0080, 8'h7C, 6'h01);
		chk("memory wins", 32'h0000, {16'h0, sup});
		$display("test memory sign done");
	endtask

	task automatic t_operand;
		op(1'b1, 1'b0, 8'h7C, 6'h00, 32'h00000000);
		chk("operand sign", 32'hFFFFFF, {8'h0, sup, sb1});
		chk("operand oe", 32'h0, {30'h0, sup_oe_n, sb1_oe_n});
		chk("reg oe", 32'h1, {30'h0, lo_oe_n, hi_oe_n});
		chk("operand data", 32'h81, {24'h0, dreg[7:0]});
		@(posedge clk);
		#1;
		chk("idle oe", 32'h3, {30'h0, sup_oe_n, sb1_oe_n});
		op(1'b0, 1'b1, 8'h7C, 6'h02, 32'h00000000);
		chk("no request sign", 32'hFFFFFF, {8'h0, sup, sb1});
		op(1'b1, 1'b0, 8'h7C, 6'h20, 32'h00000001);
		op(1'b0, 1'b1, 8'h7C, 6'h06, 32'h00000000);
		chk("positive sign", 32'h000000, {8'h0, sup, sb1});
		$display("test operand sign done");
	endtask

	// Clock enable low: a write must not land and drivers must hold
	task automatic t_freeze;
		ce = 1'b0;
		op(1'b1, 1'b0, 8'h7C, 6'h20, 32'h000000EE);
		chk("frozen operand", 32'h01, {24'h0, opnd});
		chk("frozen sign oe", 32'h0, {30'h0, sup_oe_n, sb1_oe_n});
		ce = 1'b1;
		$display("test freeze done");
	endtask

	initial begin
		repeat (4) @(posedge clk);
		#1;
		srst = 1'b0;
		t_reset();
		t_map();
		t_status();
		t_writes();
		t_mem();
		t_operand();
		t_freeze();
		@(posedge clk);
		#1;
		srst = 1'b1;
		@(posedge clk);
		#1;
		srst = 1'b0;
		t_reset();
		end_sim();
	end

	// A hang is cut short and reported as a mismatch
	initial begin
		#200000;
		fails++;
		end_sim();
	end
endmodule // dbus_register_access_sign_extend_tb
`default_nettype wire

//--- tb/mcb_model.sv
`default_nettype none
module mcb_model (
	// Clock
	input  wire logic        clk_in,
	// Read request and data to return
	input  wire logic        req_in,
	input  wire logic [15:0] word_in,
	// Memory controller bus low half
	output logic      [15:0] mcb_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] last_q;

	initial last_q = 16'h0000;

	always @(posedge clk_in) begin
		if (req_in) begin
			last_q <= word_in;
		end
	end

	// A released bus shows the inverse of its last data, so no stale sign can pass
	assign mcb_out = req_in ? word_in : ~last_q;
endmodule // mcb_model
`default_nettype wire
